// [rtl/sbd_alu.sv]
// Sized subtractor with condition flag generation
`timescale 1ns/1ps
module sbd_alu (
  input wire logic [1:0] size_i,
  input wire logic [31:0] dst_i,
  input wire logic [31:0] src_i,
  output logic [31:0] diff_o,
  output logic [4:0] flags_o
);
  logic [4:0] shamt;
  logic [31:0] dst_up;
  logic [31:0] src_up;
  logic [32:0] wide;

  // Align the operand sign to bit 31 so one subtractor serves every size
  always_comb begin
    case (size_i)
      sbd_pkg::SZ_BYTE: shamt = 5'h18;
      sbd_pkg::SZ_WORD: shamt = 5'h10;
      default: shamt = 5'h00;
    endcase
  end

  assign dst_up = dst_i << shamt;
  assign src_up = src_i << shamt;
  assign wide = {1'b0, dst_up} - {1'b0, src_up};
  assign diff_o = wide[31:0] >> shamt;

  // Borrow out of bit 31 is the sized borrow, since the low bits are zero
  always_comb begin
    flags_o[sbd_pkg::CC_C] = wide[32];
    flags_o[sbd_pkg::CC_X] = wide[32];
    flags_o[sbd_pkg::CC_N] = wide[31];
    flags_o[sbd_pkg::CC_Z] = (wide[31:0] == 32'h0000_0000);
    flags_o[sbd_pkg::CC_V] = (dst_up[31] != src_up[31]) &&
                             (wide[31] != dst_up[31]);
  end
endmodule // sbd_alu

// [rtl/sbd_pkg.sv]
// Shared constants for the subtract decode and execute block
package sbd_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_OPWORD = 6'h08;
  localparam logic [5:0] OFS_EXT = 6'h0c;
  localparam logic [5:0] OFS_DEST = 6'h10;
  localparam logic [5:0] OFS_SRC = 6'h14;
  localparam logic [5:0] OFS_CCR_IN = 6'h18;
  localparam logic [5:0] OFS_FEATURE = 6'h1c;
  localparam logic [5:0] OFS_INDEX = 6'h20;
  localparam logic [5:0] OFS_RESULT = 6'h24;
  localparam logic [5:0] OFS_CCR_OUT = 6'h28;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [4:0] RST_CCR = 5'h00;
  localparam logic [1:0] RST_FEATURE = 2'h0;
  // Control and status bit positions
  localparam int CTRL_GO = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_FLAGS = 3;
  localparam int ST_KIND = 4;
  localparam int ST_SIZE = 6;
  localparam int ST_IMMW = 8;
  localparam int FEAT_EXT = 0;
  localparam int FEAT_REDUCED = 1;
  // Flag positions in a condition byte
  localparam int CC_X = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;
  // Opcode patterns
  localparam logic [3:0] OP_ADDR_TOP = 4'h9;
  localparam logic [7:0] OP_IMM_TOP = 8'h04;
  localparam logic [3:0] OP_QUICK_TOP = 4'h5;
  localparam logic [2:0] OPM_WORD = 3'h3;
  localparam logic [2:0] OPM_LONG = 3'h7;
  // Size field codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_NONE = 2'h3;
  // Effective address mode and register codes
  localparam logic [2:0] M_DREG = 3'h0;
  localparam logic [2:0] M_AREG = 3'h1;
  localparam logic [2:0] M_INDEX = 3'h6;
  localparam logic [2:0] M_OTHER = 3'h7;
  localparam logic [2:0] R_ABS_W = 3'h0;
  localparam logic [2:0] R_ABS_L = 3'h1;
  localparam logic [2:0] R_PC_DISP = 3'h2;
  localparam logic [2:0] R_PC_INDEX = 3'h3;
  localparam logic [2:0] R_IMM = 3'h4;
  // Index extension word: full-format bit and indirect select
  localparam int IX_FULL = 8;
  localparam int IX_IIS_HI = 2;
  localparam logic [3:0] QUICK_EIGHT = 4'h8;
  // Instruction kinds reported in status
  typedef enum logic [1:0] {
    SBD_KIND_NONE,
    SBD_KIND_ADDR,
    SBD_KIND_IMM,
    SBD_KIND_QUICK
  } sbd_kind_t;
endpackage

// [rtl/sbd_top.sv]
// Subtract-address, subtract-immediate and subtract-quick execute unit
`timescale 1ns/1ps

module sbd_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic busy_o
);
  typedef enum logic [1:0] {
    SBD_IDLE,
    SBD_CALC,
    SBD_DONE
  } sbd_state_t;

  sbd_state_t state;
  logic ack_q;
  logic wr_hit;
  logic [31:0] opword;
  logic [31:0] ext_words;
  logic [31:0] dest;
  logic [31:0] src;
  logic [4:0] ccr_in;
  logic [1:0] feature;
  logic [31:0] index_ext;
  logic [31:0] result;
  logic [4:0] ccr_out;
  logic done;
  logic illegal;
  logic flags_written;
  sbd_pkg::sbd_kind_t kind;
  logic [1:0] op_size;
  logic [1:0] imm_words;
  logic [31:0] next_readdata;
  logic go;

  // Decoded fields
  logic [2:0] ea_mode;
  logic [2:0] ea_reg;
  logic [2:0] opmode;
  logic [1:0] size_fld;
  logic [3:0] quick_val;
  logic is_addr;
  logic is_imm;
  logic is_quick;
  logic index_ok;
  logic ea_legal;
  logic dec_illegal;
  sbd_pkg::sbd_kind_t dec_kind;
  logic [1:0] dec_size;
  logic [1:0] dec_immw;
  logic dec_flags;
  logic dec_full32;
  logic [31:0] alu_dst;
  logic [31:0] alu_src;
  logic [1:0] alu_size;
  logic [31:0] alu_diff;
  logic [4:0] alu_flags;
  logic [31:0] size_mask;
  logic [31:0] next_result;

  // One wait state; a low clock enable also holds the answer off, so a
  // master never sees an answer on an edge where nothing is written
  assign avs_waitrequest = (avs_read | avs_write) & ~(ack_q & ce_i);
  assign wr_hit = avs_write & ack_q & ce_i;
  assign busy_o = (state != SBD_IDLE);
  assign go = wr_hit && (avs_address == sbd_pkg::OFS_CTRL) &&
              avs_byteenable[0] && avs_writedata[sbd_pkg::CTRL_GO];

  // Merge write data into a register by byte lane
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Acknowledge toggles so back-to-back requests each see one wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // Software-written operand and control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opword <= sbd_pkg::RST_WORD;
      ext_words <= sbd_pkg::RST_WORD;
      dest <= sbd_pkg::RST_WORD;
      src <= sbd_pkg::RST_WORD;
      index_ext <= sbd_pkg::RST_WORD;
      ccr_in <= sbd_pkg::RST_CCR;
      feature <= sbd_pkg::RST_FEATURE;
    end else if (ce_i && wr_hit) begin
      case (avs_address)
        sbd_pkg::OFS_OPWORD: begin
          opword <= be_merge(opword, avs_writedata, avs_byteenable);
        end
        sbd_pkg::OFS_EXT: begin
          ext_words <= be_merge(ext_words, avs_writedata, avs_byteenable);
        end
        sbd_pkg::OFS_DEST: begin
          dest <= be_merge(dest, avs_writedata, avs_byteenable);
        end
        sbd_pkg::OFS_SRC: begin
          src <= be_merge(src, avs_writedata, avs_byteenable);
        end
        sbd_pkg::OFS_INDEX: begin
          index_ext <= be_merge(index_ext, avs_writedata, avs_byteenable);
        end
        sbd_pkg::OFS_CCR_IN: begin
          if (avs_byteenable[0]) begin
            ccr_in <= avs_writedata[4:0];
          end
        end
        sbd_pkg::OFS_FEATURE: begin
          if (avs_byteenable[0]) begin
            feature <= avs_writedata[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Opcode field extraction
  assign ea_mode = opword[5:3];
  assign ea_reg = opword[2:0];
  assign opmode = opword[8:6];
  assign size_fld = opword[7:6];
  assign is_addr = (opword[15:12] == sbd_pkg::OP_ADDR_TOP) &&
                   (opword[7:6] == 2'h3);
  assign is_imm = (opword[15:8] == sbd_pkg::OP_IMM_TOP) &&
                  (size_fld != sbd_pkg::SZ_NONE);
  assign is_quick = (opword[15:12] == sbd_pkg::OP_QUICK_TOP) &&
                    opword[8] && (size_fld != sbd_pkg::SZ_NONE);
  // Zero in the data field stands for eight
  assign quick_val = (opword[11:9] == 3'h0) ? sbd_pkg::QUICK_EIGHT :
                     {1'b0, opword[11:9]};

  // Full-format index words need the extended family; the reduced
  // core only has base displacement, no memory indirection
  always_comb begin
    index_ok = 1'b1;
    if (index_ext[sbd_pkg::IX_FULL]) begin
      if (!feature[sbd_pkg::FEAT_EXT]) begin
        index_ok = 1'b0;
      end else if (feature[sbd_pkg::FEAT_REDUCED] &&
                   (index_ext[sbd_pkg::IX_IIS_HI:0] != 3'h0)) begin
        index_ok = 1'b0;
      end
    end
  end

  // Addressing mode legality per instruction form
  always_comb begin
    ea_legal = 1'b0;
    if (is_addr) begin
      case (ea_mode)
        sbd_pkg::M_INDEX: ea_legal = index_ok;
        sbd_pkg::M_OTHER: begin
          ea_legal = (ea_reg <= sbd_pkg::R_IMM);
          if (ea_reg == sbd_pkg::R_PC_INDEX) begin
            ea_legal = index_ok;
          end
        end
        default: ea_legal = 1'b1;
      endcase
    end else if (is_imm || is_quick) begin
      case (ea_mode)
        sbd_pkg::M_AREG: begin
          // Address register only for quick, and never byte sized
          ea_legal = is_quick &&
                     (size_fld != sbd_pkg::SZ_BYTE);
        end
        sbd_pkg::M_INDEX: ea_legal = index_ok;
        sbd_pkg::M_OTHER: begin
          ea_legal = (ea_reg == sbd_pkg::R_ABS_W) ||
                     (ea_reg == sbd_pkg::R_ABS_L);
        end
        default: ea_legal = 1'b1;
      endcase
    end
  end

  // Operand selection and sizing
  always_comb begin
    dec_kind = sbd_pkg::SBD_KIND_NONE;
    dec_size = sbd_pkg::SZ_NONE;
    dec_immw = 2'h0;
    dec_flags = 1'b0;
    dec_full32 = 1'b0;
    alu_dst = dest;
    alu_src = src;
    alu_size = sbd_pkg::SZ_LONG;
    if (is_addr) begin
      dec_kind = sbd_pkg::SBD_KIND_ADDR;
      dec_full32 = 1'b1;
      dec_size = (opmode == sbd_pkg::OPM_WORD) ? sbd_pkg::SZ_WORD :
                 sbd_pkg::SZ_LONG;
      if ((ea_mode == sbd_pkg::M_OTHER) &&
          (ea_reg == sbd_pkg::R_IMM)) begin
        // Immediate source comes from the extension words
        if (opmode == sbd_pkg::OPM_WORD) begin
          alu_src = {16'h0000, ext_words[31:16]};
          dec_immw = 2'h1;
        end else begin
          alu_src = ext_words;
          dec_immw = 2'h2;
        end
      end
      if (opmode == sbd_pkg::OPM_WORD) begin
        alu_src = {{16{alu_src[15]}}, alu_src[15:0]};
      end
    end else if (is_imm) begin
      dec_kind = sbd_pkg::SBD_KIND_IMM;
      dec_size = size_fld;
      dec_flags = 1'b1;
      alu_size = size_fld;
      case (size_fld)
        sbd_pkg::SZ_BYTE: begin
          alu_src = {24'h000000, ext_words[23:16]};
          dec_immw = 2'h1;
        end
        sbd_pkg::SZ_WORD: begin
          alu_src = {16'h0000, ext_words[31:16]};
          dec_immw = 2'h1;
        end
        default: begin
          alu_src = ext_words;
          dec_immw = 2'h2;
        end
      endcase
    end else if (is_quick) begin
      dec_kind = sbd_pkg::SBD_KIND_QUICK;
      dec_size = size_fld;
      // Value is at most eight, so sign extension leaves it positive
      alu_src = {28'h0000000, quick_val};
      if (ea_mode == sbd_pkg::M_AREG) begin
        dec_full32 = 1'b1;
      end else begin
        dec_flags = 1'b1;
        alu_size = size_fld;
      end
    end
  end

  assign dec_illegal = (dec_kind == sbd_pkg::SBD_KIND_NONE) || !ea_legal;

  sbd_alu sbd_alu_inst (
    .size_i(alu_size),
    .dst_i(alu_dst),
    .src_i(alu_src),
    .diff_o(alu_diff),
    .flags_o(alu_flags)
  );

  // Bits of the destination that the operation replaces
  always_comb begin
    case (alu_size)
      sbd_pkg::SZ_BYTE: size_mask = 32'h0000_00ff;
      sbd_pkg::SZ_WORD: size_mask = 32'h0000_ffff;
      default: size_mask = 32'hffff_ffff;
    endcase
  end

  // Untouched upper bits of a data destination are kept
  assign next_result = (alu_diff & size_mask) |
                       (dest & ~size_mask);

  // Sequencer: a go while busy is ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= SBD_IDLE;
    end else if (ce_i) begin
      case (state)
        SBD_IDLE: begin
          if (go) begin
            state <= SBD_CALC;
          end
        end
        SBD_CALC: state <= SBD_DONE;
        SBD_DONE: state <= SBD_IDLE;
        default: state <= SBD_IDLE;
      endcase
    end
  end

  // Result capture; an illegal form leaves destination and flags alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result <= sbd_pkg::RST_WORD;
      ccr_out <= sbd_pkg::RST_CCR;
      illegal <= 1'b0;
      flags_written <= 1'b0;
      kind <= sbd_pkg::SBD_KIND_NONE;
      op_size <= sbd_pkg::SZ_NONE;
      imm_words <= 2'h0;
    end else if (ce_i && (state == SBD_CALC)) begin
      kind <= dec_kind;
      op_size <= dec_size;
      imm_words <= dec_immw;
      illegal <= dec_illegal;
      flags_written <= dec_flags && !dec_illegal;
      if (dec_illegal) begin
        result <= dest;
        ccr_out <= ccr_in;
      end else begin
        result <= dec_full32 ? alu_diff : next_result;
        // Address destinations keep every flag
        ccr_out <= dec_flags ? alu_flags : ccr_in;
      end
    end
  end

  // Done is set on completion and cleared by the next go
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done <= 1'b0;
    end else if (ce_i) begin
      if (state == SBD_DONE) begin
        done <= 1'b1;
      end else if (go) begin
        done <= 1'b0;
      end
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      sbd_pkg::OFS_STATUS: begin
        next_readdata[sbd_pkg::ST_BUSY] = busy_o;
        next_readdata[sbd_pkg::ST_DONE] = done;
        next_readdata[sbd_pkg::ST_ILLEGAL] = illegal;
        next_readdata[sbd_pkg::ST_FLAGS] = flags_written;
        next_readdata[sbd_pkg::ST_KIND +: 2] = kind;
        next_readdata[sbd_pkg::ST_SIZE +: 2] = op_size;
        next_readdata[sbd_pkg::ST_IMMW +: 2] = imm_words;
      end
      sbd_pkg::OFS_OPWORD: next_readdata = opword;
      sbd_pkg::OFS_EXT: next_readdata = ext_words;
      sbd_pkg::OFS_DEST: next_readdata = dest;
      sbd_pkg::OFS_SRC: next_readdata = src;
      sbd_pkg::OFS_CCR_IN: next_readdata[4:0] = ccr_in;
      sbd_pkg::OFS_FEATURE: next_readdata[1:0] = feature;
      sbd_pkg::OFS_INDEX: next_readdata = index_ext;
      sbd_pkg::OFS_RESULT: next_readdata = result;
      sbd_pkg::OFS_CCR_OUT: next_readdata[4:0] = ccr_out;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the wait cycle, so it stands at the
  // edge where waitrequest is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce_i && avs_read && !ack_q) begin
      avs_readdata <= next_readdata;
    end
  end
endmodule // sbd_top

// [tb/sbd_chk_assertions.sv]
// Port-level timing checks for the subtract execute unit
`timescale 1ns/1ps
module sbd_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request and accepted go write, seen at the answering edge
  logic req;
  logic go_acc;
  assign req = avs_read | avs_write;
  assign go_acc = avs_write & ~avs_waitrequest & ce_i & avs_byteenable[0]
    & (avs_address == sbd_pkg::OFS_CTRL) & avs_writedata[sbd_pkg::CTRL_GO];
  sequence s_busy_run;
    busy_o ##1 busy_o ##1 !busy_o;
  endsequence
  property p_busy_two;
    $rose(busy_o) |-> s_busy_run;
  endproperty
  a_busy_two: assert property (p_busy_two) else $error("busy not 2 cycles");
  property p_go_starts;
    go_acc && !busy_o |-> ##[1:2] busy_o;
  endproperty
  a_go_starts: assert property (p_go_starts) else $error("go ignored");
  property p_busy_cause;
    $rose(busy_o) |-> ($past(go_acc) || $past(go_acc, 2));
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy w/o go");
  property p_wait_first;
    $rose(req) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
  property p_wait_one;
    req && avs_waitrequest && ce_i ##1 ce_i |-> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait too long");
  property p_stall;
    req && !ce_i |-> avs_waitrequest;
  endproperty
  a_stall: assert property (p_stall) else $error("answered while stalled");
  property p_idle_free;
    !req |-> !avs_waitrequest;
  endproperty
  a_idle_free: assert property (p_idle_free) else $error("wait when idle");
  property p_read_hold;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("readdata moved");
  property p_unmapped_zero;
    avs_read && !avs_waitrequest && (avs_address > sbd_pkg::OFS_CCR_OUT
      || avs_address == sbd_pkg::OFS_CTRL) |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("bad read 0");
endmodule // sbd_chk

bind sbd_top sbd_chk sbd_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .busy_o(busy_o));

// [tb/tb_sbd_top.sv]
// Bus-driven testbench for the subtract execute unit
`timescale 1ns/1ps
module tb_sbd_top;
  logic clk_i, rst_i, ce_i, avs_read, avs_write, avs_waitrequest, busy_o;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  int fail_count, checked, q;
  logic [1:0] sz;
  logic [15:0] bad_ops [6] = '{16'h0448, 16'h047a, 16'h047c,
    16'h5108, 16'h517c, 16'h517a};
  logic [5:0] src_eas [6] = '{6'h09, 6'h3a, 6'h3b, 6'h10, 6'h00, 6'h30};
  sbd_top sbd_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .busy_o(busy_o));
  // Free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check32(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One transfer; held until waitrequest is sampled low, bounded wait
  task automatic bus_xfer(input logic wr, input logic [5:0] a,
    input logic [31:0] d, input logic [3:0] be, output logic [31:0] q_o);
    int n;
    @(posedge clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q_o = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) fail_count++;
  endtask
  task automatic bus_write(input logic [5:0] a, input logic [31:0] d,
    input logic [3:0] be);
    logic [31:0] dummy;
    bus_xfer(1'b1, a, d, be, dummy);
  endtask
  task automatic bus_read(input logic [5:0] a, output logic [31:0] d);
    bus_xfer(1'b0, a, 32'h0, 4'hf, d);
  endtask
  // Sized subtract with flags {X,N,Z,V,C}; upper bits of dest kept
  function automatic logic [36:0] sub_ref(input logic [1:0] s,
    input logic [31:0] d, input logic [31:0] v);
    logic [31:0] m, rm;
    logic [32:0] w;
    int t;
    logic c, ov;
    m = (s == 2'h0) ? 32'hff : (s == 2'h1) ? 32'hffff : 32'hffff_ffff;
    t = (s == 2'h0) ? 7 : (s == 2'h1) ? 15 : 31;
    w = {1'b0, d & m} - {1'b0, v & m};
    c = w[32];
    rm = w[31:0] & m;
    ov = (d[t] != v[t]) && (rm[t] != d[t]);
    return {c, rm[t], rm == 32'h0, ov, c, (d & ~m) | rm};
  endfunction
  // Load operands, start, poll for done, compare outcome
  task automatic exec(input logic [15:0] op, input logic [31:0] ext, dst,
    src, input logic [4:0] cc, input logic [1:0] ft, input logic [31:0] ix,
    input logic ill, input logic [1:0] kd, input logic [36:0] e);
    logic [31:0] st;
    int n;
    logic [1:0] esz, ew;
    logic fw;
    bus_write(sbd_pkg::OFS_OPWORD, {16'h0, op}, 4'hf);
    bus_write(sbd_pkg::OFS_EXT, ext, 4'hf);
    bus_write(sbd_pkg::OFS_DEST, dst, 4'hf);
    bus_write(sbd_pkg::OFS_SRC, src, 4'hf);
    bus_write(sbd_pkg::OFS_CCR_IN, {27'h0, cc}, 4'hf);
    bus_write(sbd_pkg::OFS_FEATURE, {30'h0, ft}, 4'hf);
    bus_write(sbd_pkg::OFS_INDEX, ix, 4'hf);
    bus_write(sbd_pkg::OFS_CTRL, 32'h1, 4'hf);
    n = 0;
    do begin
      bus_read(sbd_pkg::OFS_STATUS, st);
      n++;
    end while (st[sbd_pkg::ST_DONE] !== 1'b1 && n < 20);
    check32("done", 32'h1, {31'h0, st[sbd_pkg::ST_DONE]});
    check32("illegal", {31'h0, ill}, {31'h0, st[sbd_pkg::ST_ILLEGAL]});
    if (!ill) check32("kind", {30'h0, kd}, {30'h0, st[5:4]});
    // Expected size and extension words from the opcode encoding
    esz = (op[8:6] == 3'h3) ? 2'h1 : 2'h2;
    ew = (op[5:0] == 6'h3c) ? esz : 2'h0;
    if (kd != 2'h1) esz = op[7:6];
    if (kd == 2'h2) ew = (op[7:6] == 2'h2) ? 2'h2 : 2'h1;
    if (kd == 2'h3) ew = 2'h0;
    fw = !ill && (kd == 2'h2 || (kd == 2'h3 && op[5:3] != 3'h1));
    if (!ill) check32("size", {30'h0, esz},
      {30'h0, st[sbd_pkg::ST_SIZE +: 2]});
    if (!ill) check32("immw", {30'h0, ew},
      {30'h0, st[sbd_pkg::ST_IMMW +: 2]});
    check32("flagsw", {31'h0, fw},
      {31'h0, st[sbd_pkg::ST_FLAGS]});
    bus_read(sbd_pkg::OFS_RESULT, st);
    check32("result", e[31:0], st);
    bus_read(sbd_pkg::OFS_CCR_OUT, st);
    check32("ccr_out", {27'h0, e[36:32]}, st);
    $display("case %h done", op);
  endtask
  // Watchdog well beyond the thousand or so cycles the tests need
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end
  initial begin
    fail_count = 0;
    checked = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, unmapped place, write-only control, byte lanes
    bus_read(sbd_pkg::OFS_OPWORD, rd);
    check32("opword_rst", sbd_pkg::RST_WORD, rd);
    bus_read(sbd_pkg::OFS_CCR_IN, rd);
    check32("ccr_rst", 32'h0, rd);
    bus_write(6'h3c, 32'hdead_beef, 4'hf);
    bus_read(6'h3c, rd);
    check32("unmapped", 32'h0, rd);
    bus_read(sbd_pkg::OFS_CTRL, rd);
    check32("ctrl_read", 32'h0, rd);
    bus_write(sbd_pkg::OFS_DEST, 32'h1122_3344, 4'hf);
    bus_write(sbd_pkg::OFS_DEST, 32'haabb_ccdd, 4'h2);
    bus_read(sbd_pkg::OFS_DEST, rd);
    check32("lanes", 32'h1122_cc44, rd);
    // Stalled read: clock enable low delays the answer
    ce_i <= 1'b0;
    fork
      bus_read(sbd_pkg::OFS_DEST, rd);
      begin
        repeat (4) @(posedge clk_i);
        ce_i <= 1'b1;
      end
    join
    check32("stall_read", 32'h1122_cc44, rd);
    // Clock enable low in the answer cycle must hold the write off
    fork
      bus_write(sbd_pkg::OFS_SRC, 32'h0bad_cafe, 4'hf);
      begin
        repeat (2) @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        ce_i <= 1'b1;
      end
    join
    bus_read(sbd_pkg::OFS_SRC, rd);
    check32("stall_write", 32'h0bad_cafe, rd);
    $display("test bus done");
    // Immediate subtract, byte word long
    exec(16'h0400, 32'hff81_0000, 32'h1234_5600, 0, 5'h00, 2'h0, 0, 1'b0,
      2'h2, sub_ref(2'h0, 32'h1234_5600, 32'h81));
    exec(16'h0453, 32'h8000_1234, 32'haaaa_0000, 0, 5'h00, 2'h0, 0, 1'b0,
      2'h2, sub_ref(2'h1, 32'haaaa_0000, 32'h8000));
    exec(16'h04b9, 32'h0000_0005, 32'h5, 0, 5'h1f, 2'h0, 0, 1'b0,
      2'h2, sub_ref(2'h2, 32'h5, 32'h5));
    $display("test immediate done");
    // Quick subtract, every data field value across sizes
    for (int d = 0; d < 8; d++) begin
      q = (d == 0) ? 8 : d;
      sz = 2'(d % 3);
      exec(16'(16'h5100 | (d << 9) | (sz << 6)), 0, 32'h4, 0, 5'h00, 2'h0,
        0, 1'b0, 2'h3, sub_ref(sz, 32'h4, 32'(q)));
    end
    exec(16'h574a, 0, 32'h0001_0001, 0, 5'h1f, 2'h0, 0, 1'b0, 2'h3,
      {5'h1f, 32'h0000_fffe});
    $display("test quick done");
    // Illegal destinations leave result and flags untouched
    foreach (bad_ops[i]) exec(bad_ops[i], 0, 32'h5555_aaaa, 0, 5'h0a, 2'h0,
      0, 1'b1, 2'h0, {5'h0a, 32'h5555_aaaa});
    $display("test illegal done");
    // Address subtract: word immediate sign-extended, long sources
    exec(16'h90fc, 32'h8000_0000, 32'h0, 0, 5'h15, 2'h0, 0, 1'b0, 2'h1,
      {5'h15, 32'h0000_8000});
    foreach (src_eas[i]) exec(16'h91c0 | {10'h0, src_eas[i]}, 0,
      32'h100, 32'h10, 5'h0c, 2'h0, 0, 1'b0, 2'h1,
      {5'h0c, 32'h0000_00f0});
    $display("test address done");
    // Full-format index word versus family features
    exec(16'h04b0, 32'h1, 32'h3, 0, 5'h00, 2'h1, 32'h101, 1'b0, 2'h2,
      sub_ref(2'h2, 32'h3, 32'h1));
    exec(16'h04b0, 32'h1, 32'h3, 0, 5'h00, 2'h0, 32'h101, 1'b1, 2'h2,
      {5'h00, 32'h3});
    exec(16'h04b0, 32'h1, 32'h3, 0, 5'h00, 2'h3, 32'h101, 1'b1, 2'h2,
      {5'h00, 32'h3});
    exec(16'h04b0, 32'h1, 32'h3, 0, 5'h00, 2'h3, 32'h100, 1'b0, 2'h2,
      sub_ref(2'h2, 32'h3, 32'h1));
    $display("test features done");
    report_and_stop();
  end
endmodule // tb_sbd_top
